// [pm_pin_mux.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pm_defines.svh"
module pm_pin_mux (
  // Clock and reset; the clock is the interface clock.
  input wire logic clk_i,
  input wire logic rst_i,
  // AXI4-Lite register bus.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port E pins.
  input wire logic [7:0] port_e_i,
  output logic [7:0] port_e_o,
  output logic [7:0] port_e_oe_o,
  // Shared interface pins.
  input wire logic [5:0] ready_pin_i,
  input wire logic [1:0] fifo_select_pins_i,
  output logic [5:0] control_strobe_out_o,
  // Internal sources on the same clock.
  input wire pm_pkg::pm_uart_s uart_i,
  input wire logic waveform_addr_bit8_i,
  input wire logic [5:0] waveform_ctl_i,
  input wire pm_pkg::pm_fifo_flags_s fifo_flags_i,
  // Internal destinations.
  output logic [5:0] waveform_ready_o,
  output logic slave_read_strobe_o,
  output logic slave_write_strobe_o,
  output logic ext_irq_six_o,
  output logic timer2_reload_trigger_o
);
  import pm_pkg::*;

  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [15:0] pins_sync;
  logic [7:0] pe_sync;
  logic [5:0] rdy_sync;
  logic [1:0] sel_sync;

  // Software registers.
  logic [7:0] func_sel_reg, func_sel_next;
  logic [7:0] port_out_reg, port_out_next;
  logic [7:0] port_dir_reg, port_dir_next;
  pm_mode_e if_mode_reg, if_mode_next;
  logic [1:0] polarity_reg, polarity_next;
  logic [7:0] t2_control_reg, t2_control_next;

  // Pin side registers.
  logic [7:0] pe_out_reg, pe_out_next;
  logic [7:0] pe_oe_reg, pe_oe_next;
  logic [5:0] ctl_reg, ctl_next;
  logic [5:0] ready_reg, ready_next;
  logic rd_strobe_reg, rd_strobe_next;
  logic wr_strobe_reg, wr_strobe_next;
  logic pe5_prev_reg;
  logic pe6_prev_reg;
  logic irq6_reg, irq6_next;
  logic reload_reg, reload_next;

  // Bus slave.
  pm_axil_slave #(
    .AW(8)
  ) u_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_hit_i(wr_hit),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_hit_i(rd_hit)
  );

  // Every pin input passes two flip-flops on the interface clock.
  pm_sync #(
    .W(16)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({fifo_select_pins_i, ready_pin_i, port_e_i}),
    .q_o(pins_sync)
  ); // RULE_15

  assign pe_sync = pins_sync[7:0];
  assign rdy_sync = pins_sync[13:8];
  assign sel_sync = pins_sync[15:14];

  // Write decode; only the low byte lane carries register bits.
  always_comb
  begin
    func_sel_next = func_sel_reg;
    port_out_next = port_out_reg;
    port_dir_next = port_dir_reg;
    if_mode_next = if_mode_reg;
    polarity_next = polarity_reg;
    t2_control_next = t2_control_reg;
    wr_hit = 1'b1;
    case (wr_addr)
      `PM_FUNC_SEL_OFS:
      begin
        if (wr_en && wr_strb[0])
        begin
          func_sel_next = wr_data[7:0] & `PM_ALT_MASK;
        end
      end
      `PM_PORT_OUT_OFS:
      begin
        if (wr_en && wr_strb[0])
        begin
          port_out_next = wr_data[7:0];
        end
      end
      `PM_PORT_DIR_OFS:
      begin
        if (wr_en && wr_strb[0])
        begin
          port_dir_next = wr_data[7:0];
        end
      end
      `PM_IF_CONFIG_OFS:
      begin
        if (wr_en && wr_strb[0])
        begin
          if_mode_next = pm_mode_e'(wr_data[1:0]);
        end
      end
      `PM_POLARITY_OFS:
      begin
        if (wr_en && wr_strb[0])
        begin
          polarity_next = {wr_data[`PM_POL_RD_BIT], wr_data[`PM_POL_WR_BIT]};
        end
      end
      `PM_T2_CONTROL_OFS:
      begin
        if (wr_en && wr_strb[0])
        begin
          t2_control_next = wr_data[7:0];
        end
      end
      `PM_PORT_PIN_OFS, `PM_STATUS_OFS:
      begin
        wr_hit = 1'b1;
      end
      default:
      begin
        wr_hit = 1'b0;
      end
    endcase
  end

  // Read decode; unused upper bits read as zero.
  always_comb
  begin
    rd_data = 32'h0;
    rd_hit = 1'b1;
    case (rd_addr)
      `PM_FUNC_SEL_OFS: rd_data[7:0] = func_sel_reg;
      `PM_PORT_OUT_OFS: rd_data[7:0] = port_out_reg;
      `PM_PORT_DIR_OFS: rd_data[7:0] = port_dir_reg;
      `PM_PORT_PIN_OFS: rd_data[7:0] = pe_sync;
      `PM_IF_CONFIG_OFS: rd_data[1:0] = if_mode_reg;
      `PM_POLARITY_OFS:
      begin
        rd_data[`PM_POL_RD_BIT] = polarity_reg[1];
        rd_data[`PM_POL_WR_BIT] = polarity_reg[0];
      end
      `PM_T2_CONTROL_OFS: rd_data[7:0] = t2_control_reg;
      `PM_STATUS_OFS: rd_data[7:0] = {sel_sync, rdy_sync};
      default: rd_hit = 1'b0;
    endcase
  end

  // Port E output and enable per pin, chosen by the select bit.
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pe_out_next[i] = port_out_reg[i]; // RULE_16
      pe_oe_next[i] = port_dir_reg[i]; // RULE_16
    end
    if (func_sel_reg[`PM_PIN_UART0])
    begin
      pe_oe_next[`PM_PIN_UART0] = 1'b1;
      pe_out_next[`PM_PIN_UART0] = (uart_i.mode0 == `PM_UART_SYNC_MODE) ? uart_i.data0 : 1'b1; // RULE_01
    end
    if (func_sel_reg[`PM_PIN_UART1])
    begin
      pe_oe_next[`PM_PIN_UART1] = 1'b1;
      pe_out_next[`PM_PIN_UART1] = (uart_i.mode1 == `PM_UART_SYNC_MODE) ? uart_i.data1 : 1'b1; // RULE_02
    end
    if (func_sel_reg[`PM_PIN_IRQ6])
    begin
      pe_oe_next[`PM_PIN_IRQ6] = 1'b0;
      pe_out_next[`PM_PIN_IRQ6] = 1'b0;
    end
    if (func_sel_reg[`PM_PIN_RELOAD])
    begin
      pe_oe_next[`PM_PIN_RELOAD] = 1'b0;
      pe_out_next[`PM_PIN_RELOAD] = 1'b0;
    end
    if (func_sel_reg[`PM_PIN_ADDR8])
    begin
      pe_oe_next[`PM_PIN_ADDR8] = 1'b1;
      pe_out_next[`PM_PIN_ADDR8] = waveform_addr_bit8_i; // RULE_05
    end
  end

  // Edge events on the alternate input pins, one cycle pulses.
  always_comb
  begin
    irq6_next = func_sel_reg[`PM_PIN_IRQ6] && pe_sync[`PM_PIN_IRQ6] && !pe5_prev_reg; // RULE_03
    reload_next = func_sel_reg[`PM_PIN_RELOAD] && t2_control_reg[`PM_T2_EXT_EN_BIT]
                  && !pe_sync[`PM_PIN_RELOAD] && pe6_prev_reg; // RULE_04
  end

  // Shared pins steered by the interface mode.
  always_comb
  begin
    ctl_next = `PM_CTL_RST;
    ready_next = 6'h0;
    rd_strobe_next = 1'b0;
    wr_strobe_next = 1'b0;
    case (if_mode_reg) // RULE_07
      PM_MODE_WAVE:
      begin
        ctl_next = waveform_ctl_i; // RULE_14
        ready_next = rdy_sync; // RULE_13
      end
      PM_MODE_FIFO:
      begin
        ctl_next[5:3] = waveform_ctl_i[5:3];
        ctl_next[0] = fifo_flags_i.prog[sel_sync]; // RULE_10
        ctl_next[1] = fifo_flags_i.full[sel_sync]; // RULE_11
        ctl_next[2] = fifo_flags_i.empty[sel_sync]; // RULE_12
        ready_next[5:2] = rdy_sync[5:2]; // RULE_13
        rd_strobe_next = ~(rdy_sync[0] ^ polarity_reg[1]); // RULE_08
        wr_strobe_next = ~(rdy_sync[1] ^ polarity_reg[0]); // RULE_09
      end
      default:
      begin
        ready_next[5:2] = rdy_sync[5:2];
      end
    endcase
  end

  // All state registers; pins come up as general I/O and controls high.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      func_sel_reg <= `PM_FUNC_SEL_RST; // RULE_06
      port_out_reg <= `PM_PORT_OUT_RST;
      port_dir_reg <= `PM_PORT_DIR_RST;
      if_mode_reg <= PM_MODE_PORTS;
      polarity_reg <= `PM_POLARITY_RST;
      t2_control_reg <= `PM_T2_CONTROL_RST;
      pe_out_reg <= `PM_PORT_OUT_RST;
      pe_oe_reg <= `PM_PORT_DIR_RST;
      ctl_reg <= `PM_CTL_RST; // RULE_14
      ready_reg <= 6'h0;
      rd_strobe_reg <= 1'b0;
      wr_strobe_reg <= 1'b0;
      pe5_prev_reg <= 1'b0;
      pe6_prev_reg <= 1'b0;
      irq6_reg <= 1'b0;
      reload_reg <= 1'b0;
    end
    else
    begin
      func_sel_reg <= func_sel_next;
      port_out_reg <= port_out_next;
      port_dir_reg <= port_dir_next;
      if_mode_reg <= if_mode_next;
      polarity_reg <= polarity_next;
      t2_control_reg <= t2_control_next;
      pe_out_reg <= pe_out_next;
      pe_oe_reg <= pe_oe_next;
      ctl_reg <= ctl_next;
      ready_reg <= ready_next;
      rd_strobe_reg <= rd_strobe_next;
      wr_strobe_reg <= wr_strobe_next;
      pe5_prev_reg <= pe_sync[`PM_PIN_IRQ6];
      pe6_prev_reg <= pe_sync[`PM_PIN_RELOAD];
      irq6_reg <= irq6_next;
      reload_reg <= reload_next;
    end
  end

  // Outputs come straight from registers.
  assign port_e_o = pe_out_reg;
  assign port_e_oe_o = pe_oe_reg;
  assign control_strobe_out_o = ctl_reg;
  assign waveform_ready_o = ready_reg;
  assign slave_read_strobe_o = rd_strobe_reg;
  assign slave_write_strobe_o = wr_strobe_reg;
  assign ext_irq_six_o = irq6_reg;
  assign timer2_reload_trigger_o = reload_reg;

endmodule
`default_nettype wire

// [pm_defines.svh]
// What this block does
// RULE_01 - Port E pin 3 alternate drives UART0 sync data in mode 0, else 1.
// RULE_02 - Port E pin 4 alternate drives UART1 sync data in mode 0, high otherwise.
// RULE_03 - Port E pin 5 alternate is interrupt six input, raised on rising edge.
// RULE_04 - Port E pin 6 alternate falling edge reloads timer 2 when external enable set.
// RULE_05 - Port E pin 7 alternate outputs waveform engine address bit 8.
// RULE_06 - After reset every port E pin is general purpose bidirectional I/O.
// RULE_07 - Two-bit interface mode picks waveform engine use or slave FIFO use of shared pins.
// RULE_08 - FIFO mode read strobe comes from master, polarity set by polarity bit 3.
// RULE_09 - FIFO mode write strobe comes from master, polarity set by polarity bit 2.
// RULE_10 - Flag A reports programmable level of the FIFO picked by select pins.
// RULE_11 - Flag B reports full of the FIFO picked by select pins.
// RULE_12 - Flag C reports empty of the FIFO picked by select pins.
// RULE_13 - Six ready inputs; 2 to 5 dedicated, 0 and 1 shared with strobes.
// RULE_14 - Six control outputs; controls and shared flags are high after reset.
// RULE_15 - Interface clock times all FIFO control signals and waveform pin activity.
// RULE_16 - With select bit clear, pin follows direction and output registers only.
`ifndef PM_DEFINES_SVH
`define PM_DEFINES_SVH

// Register byte offsets.
`define PM_FUNC_SEL_OFS 8'h00
`define PM_PORT_OUT_OFS 8'h04
`define PM_PORT_DIR_OFS 8'h08
`define PM_PORT_PIN_OFS 8'h0c
`define PM_IF_CONFIG_OFS 8'h10
`define PM_POLARITY_OFS 8'h14
`define PM_T2_CONTROL_OFS 8'h18
`define PM_STATUS_OFS 8'h1c

// Reset values.
`define PM_FUNC_SEL_RST 8'h00
`define PM_PORT_OUT_RST 8'h00
`define PM_PORT_DIR_RST 8'h00
`define PM_IF_MODE_RST 2'h0
`define PM_POLARITY_RST 2'h0
`define PM_T2_CONTROL_RST 8'h00
`define PM_CTL_RST 6'h3f

// Field positions.
`define PM_ALT_MASK 8'hf8
`define PM_POL_RD_BIT 3
`define PM_POL_WR_BIT 2
`define PM_T2_EXT_EN_BIT 3
`define PM_PIN_UART0 3
`define PM_PIN_UART1 4
`define PM_PIN_IRQ6 5
`define PM_PIN_RELOAD 6
`define PM_PIN_ADDR8 7
`define PM_UART_SYNC_MODE 2'h0

`endif

// [pm_pkg.sv]
package pm_pkg;

  // Use of the shared waveform and FIFO pins.
  typedef enum logic [1:0] {
    PM_MODE_PORTS = 2'b00,
    PM_MODE_RSVD = 2'b01,
    PM_MODE_WAVE = 2'b10,
    PM_MODE_FIFO = 2'b11
  } pm_mode_e;

  // Write channel state of the register slave.
  typedef enum logic {
    PM_WR_IDLE = 1'b0,
    PM_WR_RESP = 1'b1
  } pm_wr_state_e;

  // Status of the four internal FIFOs, one bit per FIFO.
  typedef struct packed {
    logic [3:0] prog;
    logic [3:0] full;
    logic [3:0] empty;
  } pm_fifo_flags_s;

  // Serial port state that the pin mux needs.
  typedef struct packed {
    logic [1:0] mode0;
    logic data0;
    logic [1:0] mode1;
    logic data1;
  } pm_uart_s;

endpackage

// [pm_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module pm_sync #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous inputs and their synchronised copies.
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // Two flip-flops per bit; only the second stage is visible outside.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;

endmodule
`default_nettype wire

// [pm_axil_slave.sv]
`timescale 1ns/10ps
`default_nettype none
module pm_axil_slave
  import pm_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // AXI4-Lite write channels.
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register file side.
  output logic wr_en_o,
  output logic [AW-1:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic [3:0] wr_strb_o,
  input wire logic wr_hit_i,
  output logic [AW-1:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_hit_i
);

  pm_wr_state_e wst_reg, wst_next;
  logic aw_got_reg, aw_got_next;
  logic w_got_reg, w_got_next;
  logic [AW-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic aw_hs;
  logic w_hs;

  // Address and data are taken in either order while no response is pending.
  assign s_axi_awready = (wst_reg == PM_WR_IDLE) && !aw_got_reg;
  assign s_axi_wready = (wst_reg == PM_WR_IDLE) && !w_got_reg;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign wr_addr_o = aw_got_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data_o = w_got_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb_o = w_got_reg ? wstrb_reg : s_axi_wstrb;
  assign wr_en_o = (aw_got_reg || aw_hs) && (w_got_reg || w_hs);
  assign s_axi_bvalid = (wst_reg == PM_WR_RESP);
  assign s_axi_bresp = bresp_reg;

  // Write channel next state; the write lands in the cycle the later half is taken.
  always_comb
  begin
    wst_next = wst_reg;
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    awaddr_next = aw_hs ? s_axi_awaddr : awaddr_reg;
    wdata_next = w_hs ? s_axi_wdata : wdata_reg;
    wstrb_next = w_hs ? s_axi_wstrb : wstrb_reg;
    bresp_next = bresp_reg;
    case (wst_reg)
      PM_WR_IDLE:
      begin
        if (wr_en_o)
        begin
          wst_next = PM_WR_RESP;
          aw_got_next = 1'b0;
          w_got_next = 1'b0;
          bresp_next = wr_hit_i ? 2'h0 : 2'h3;
        end
        else
        begin
          aw_got_next = aw_got_reg || aw_hs;
          w_got_next = w_got_reg || w_hs;
        end
      end
      PM_WR_RESP:
      begin
        if (s_axi_bready)
        begin
          wst_next = PM_WR_IDLE;
        end
      end
      default:
      begin
        wst_next = PM_WR_IDLE;
      end
    endcase
  end

  // Read channel: data are captured at the address handshake.
  assign s_axi_arready = !rvalid_reg;
  assign rd_addr_o = s_axi_araddr;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_comb
  begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rdata_next = rd_hit_i ? rd_data_i : 32'h0;
      rresp_next = rd_hit_i ? 2'h0 : 2'h3;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end
  end

  // Registers of both channels.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wst_reg <= PM_WR_IDLE;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= 2'h0;
    end
    else
    begin
      wst_reg <= wst_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

endmodule
`default_nettype wire

// [pm_pin_mux_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module pm_pin_mux_sva (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus outputs and qualifiers.
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Pin side outputs.
  input wire logic [7:0] port_e_o,
  input wire logic [7:0] port_e_oe_o,
  input wire logic [5:0] control_strobe_out_o,
  input wire logic slave_read_strobe_o,
  input wire logic slave_write_strobe_o,
  input wire logic ext_irq_six_o,
  input wire logic timer2_reload_trigger_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // First edge after reset release, a pending write answer, a taken read address.
  sequence s_released; $fell(rst_i); endsequence
  sequence s_wr_wait; s_axi_bvalid && !s_axi_bready; endsequence
  sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
  chk_ctl_reset_high: assert property (s_released |-> control_strobe_out_o == 6'h3f)
    else $error("control outputs not high after reset");
  chk_pins_reset_gpio: assert property (s_released |-> port_e_oe_o == 8'h00 && port_e_o == 8'h00)
    else $error("port pins driven after reset");
  chk_strobe_reset_idle: assert property (s_released |-> !slave_read_strobe_o && !slave_write_strobe_o)
    else $error("slave strobe active after reset");
  chk_bvalid_holds: assert property (s_wr_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during response");
  chk_decerr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b11 |-> s_axi_rdata == 32'h0)
    else $error("decode error with nonzero data");
  chk_irq_one_pulse: assert property ($rose(ext_irq_six_o) |=> !ext_irq_six_o)
    else $error("interrupt pulse too long");
  chk_reload_one_pulse: assert property (timer2_reload_trigger_o |=> !timer2_reload_trigger_o)
    else $error("reload pulse too long");
endmodule
bind pm_pin_mux pm_pin_mux_sva chk (.*);
`default_nettype wire

// [pm_fifo_master.sv]
`timescale 1ns/10ps
`default_nettype none
module pm_fifo_master (
  // Strobe polarity, bit 1 read and bit 0 write, 1 is active high.
  input wire logic [1:0] pol_i,
  // Requested strobes, dedicated ready levels and FIFO choice.
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [3:0] rdy_i,
  input wire logic [1:0] sel_i,
  // Pins toward the device.
  output logic [5:0] ready_pin_o,
  output logic [1:0] sel_o
);
  // Strobes rest at their inactive level unless requested.
  assign ready_pin_o[0] = pol_i[1] ? rd_i : ~rd_i;
  assign ready_pin_o[1] = pol_i[0] ? wr_i : ~wr_i;
  assign ready_pin_o[5:2] = rdy_i;
  assign sel_o = sel_i;
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pm_pkg::*;
  // Stimulus, responses and bookkeeping.
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, port_e_i = 8'h00, pe_o, pe_oe, eo;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, v, got;
  logic [1:0] bresp, rresp, resp, pol = 2'h0, sel = 2'h0, fsel;
  logic awready, wready, bvalid, arready, rvalid, rs_o, ws_o, irq_o, rl_o;
  logic rd = 1'b0, wr = 1'b0, addr8 = 1'b0;
  logic [3:0] rdy = 4'h0;
  logic [5:0] pins, ctl_o, wctl = 6'h00, wrdy_o, raw;
  pm_uart_s uart = '0;
  pm_fifo_flags_s flags = '0;
  int err_count = 0, n_compared = 0, seed = 32'ha49673fa, ci, cr;
  int msk [7] = '{8'hf8, 8'hff, 8'hff, 0, 8'h03, 8'h0c, 8'hff};
  // Device and far-side master.
  pm_pin_mux dut (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_e_i(port_e_i), .port_e_o(pe_o), .port_e_oe_o(pe_oe), .ready_pin_i(pins),
    .fifo_select_pins_i(fsel), .control_strobe_out_o(ctl_o), .uart_i(uart),
    .waveform_addr_bit8_i(addr8), .waveform_ctl_i(wctl), .fifo_flags_i(flags),
    .waveform_ready_o(wrdy_o), .slave_read_strobe_o(rs_o), .slave_write_strobe_o(ws_o),
    .ext_irq_six_o(irq_o), .timer2_reload_trigger_o(rl_o));
  pm_fifo_master mst (.pol_i(pol), .rd_i(rd), .wr_i(wr), .rdy_i(rdy), .sel_i(sel),
    .ready_pin_o(pins), .sel_o(fsel));
  // Free-running 125 MHz clock.
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  // Prints counts and the verdict, then stops.
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Compares one value with its expectation.
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    if (g !== e)
      err_count++;
  endtask
  // Ends the run when a wait used its whole bound.
  task automatic bound(input int n);
    if (n >= 64)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // One register write; both halves offered together, each released when taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64 && !(aw_ok && w_ok); n++)
    begin
      @(posedge clk_i);
      aw_ok = aw_ok || awready === 1'b1;
      w_ok = w_ok || wready === 1'b1;
      if (aw_ok)
        awvalid <= 1'b0;
      if (w_ok)
        wvalid <= 1'b0;
    end
    bound(n);
    for (n = 0; n < 64 && bvalid !== 1'b1; n++)
      @(posedge clk_i);
    bound(n);
    r = bresp;
    bready <= 1'b0;
  endtask
  // One register read; an edge passes first so back to back calls never drive twice at once.
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_ok;
    ar_ok = 1'b0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64 && !ar_ok; n++)
    begin
      @(posedge clk_i);
      ar_ok = arready === 1'b1;
    end
    bound(n);
    arvalid <= 1'b0;
    for (n = 0; n < 64 && rvalid !== 1'b1; n++)
      @(posedge clk_i);
    bound(n);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Counts edge-event pulses over eight edges.
  task automatic pulses();
    ci = 0;
    cr = 0;
    repeat (8)
    begin
      @(posedge clk_i);
      ci += (irq_o !== 1'b0);
      cr += (rl_o !== 1'b0);
    end
  endtask
  // Main sequence.
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    cmp(pe_oe, 8'h00);
    cmp(ctl_o, 6'h3f);
    for (int i = 0; i < 7; i++)
    begin
      axi_rd(i * 4, got, resp);
      cmp(got, 0);
    end
    $display("test reset done");
    for (int i = 0; i < 7; i++)
    begin
      v = $random(seed);
      axi_wr(i * 4, v, resp);
      cmp(resp, 2'b00);
      axi_rd(i * 4, got, resp);
      if (i != 3)
        cmp(got, v & msk[i]);
    end
    axi_wr(8'h20, v, resp);
    cmp(resp, 2'b11);
    axi_rd(8'h20, got, resp);
    cmp({resp, got}, {2'b11, 32'h0});
    $display("test registers done");
    repeat (4)
    begin
      v = $random(seed);
      axi_wr(8'h00, 0, resp);
      axi_wr(8'h04, v[7:0], resp);
      axi_wr(8'h08, v[15:8], resp);
      port_e_i <= v[23:16];
      repeat (4) @(posedge clk_i);
      cmp({pe_oe, pe_o}, v[15:0]);
      axi_rd(8'h0c, got, resp);
      cmp(got, v[23:16]);
    end
    $display("test gpio done");
    axi_wr(8'h00, 8'hf8, resp);
    axi_wr(8'h04, 8'hff, resp);
    axi_wr(8'h08, 8'hff, resp);
    for (int k = 0; k < 16; k++)
    begin
      v = $random(seed);
      uart <= {k[1:0], v[0], k[3:2], v[1]};
      addr8 <= v[2];
      repeat (3) @(posedge clk_i);
      eo = {v[2], 2'b00, (k[3:2] == 0) ? v[1] : 1'b1, (k[1:0] == 0) ? v[0] : 1'b1, 3'b111};
      cmp({pe_oe, pe_o}, {8'h9f, eo});
    end
    $display("test alternate done");
    for (int k = 0; k < 4; k++)
    begin
      port_e_i <= 8'h40;
      axi_wr(8'h00, k[0] ? 8'hf8 : 8'h00, resp);
      axi_wr(8'h18, k[1] ? 8'h08 : 8'h00, resp);
      repeat (4) @(posedge clk_i);
      port_e_i <= 8'h20;
      pulses();
      cmp(ci, k[0]);
      cmp(cr, k[0] & k[1]);
    end
    $display("test edges done");
    for (int m = 0; m < 4; m++)
      for (int p = 0; p < 4; p++)
      begin
        axi_wr(8'h10, m, resp);
        axi_wr(8'h14, p << 2, resp);
        v = $random(seed);
        pol <= p[1:0];
        {sel, rdy, wr, rd} <= v[7:0];
        wctl <= v[13:8];
        flags <= v[25:14];
        repeat (5) @(posedge clk_i);
        raw = {v[5:2], p[0] ? v[1] : ~v[1], p[1] ? v[0] : ~v[0]};
        eo = {2'b00, v[13:11], flags.empty[sel], flags.full[sel], flags.prog[sel]};
        cmp(ctl_o, m == 2 ? v[13:8] : m == 3 ? eo : 8'h3f);
        cmp(wrdy_o, m == 2 ? raw : {raw[5:2], 2'b00});
        cmp({rs_o, ws_o}, m == 3 ? {v[0], v[1]} : 2'b00);
        axi_rd(8'h1c, got, resp);
        cmp(got, {v[7:6], raw});
      end
    $display("test modes done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
